// ===== rcg_top.sv
// Reset cause record, peripheral clock gate and write lock
`timescale 1ns/1ps
module rcg_top
    import rcg_pkg::*;
(
    input  wire logic                  core_clk,     // System clock, 40 MHz
    input  wire logic                  rst_n,        // Synchronous reset, active low
    input  wire logic                  por_evt,      // Power-on reset event pin
    input  wire logic                  dbg_evt,      // Debug-port reset event pin
    input  wire logic                  wdt_evt,      // Watchdog reset event
    input  wire logic                  pin_evt,      // External reset pin event
    input  wire logic                  req_valid,    // Register request
    input  wire logic                  req_write,    // Request is a write
    input  wire logic                  req_control_register_move, // Request via control-register move
    input  wire logic [11:0]           req_addr,     // Register address
    input  wire logic [2:0]            req_ctx,      // Issuing context
    input  wire logic [31:0]           req_wdata,    // Write data
    output logic                       rsp_valid,    // Read data valid
    output logic [31:0]                rsp_rdata,    // Read data
    output logic                       full_init,    // Registers to defaults
    output logic                       part_init,    // Registers kept
    output logic [RCG_GATE_W-1:0]      periph_clk_en, // Peripheral clock enables
    output logic                       wdt_clk_en    // Watchdog clock enable
);

    // State of the block, apart from the clock-enable register stage in rcg_clk_en
    typedef struct packed {
        logic [RCG_EV_N-1:0]   s1;     // Synchroniser first stage
        logic [RCG_EV_N-1:0]   s2;     // Synchroniser second stage
        logic [RCG_EV_N-1:0]   s3;     // Edge reference
        logic [RCG_STAT_W-1:0] stat;   // Reset cause flags
        logic [RCG_GATE_W-1:0] gate;   // Clock stop mask
        logic                  lock;   // Write lock
        logic                  rvld;   // Read answer valid
        logic [31:0]           rdata;  // Read answer
        logic                  full;   // Full init pulse
        logic                  part;   // Partial init pulse
    } rcg_st_t;

    rcg_st_t             q;      // Current state
    rcg_st_t             d;      // Next state
    logic [RCG_EV_N-1:0] pins;   // Raw event inputs
    logic [RCG_EV_N-1:0] rise;   // Synchronised event edges
    logic                hard;   // Power-on or debug reset
    logic [31:0]         rd_mux; // Read value of target

    rcg_acc_if acc ();  // Checker connection

    assign pins = {pin_evt, wdt_evt, dbg_evt, por_evt};
    // Edge taken from stages two and three only
    assign rise = q.s2 & ~q.s3;
    assign hard = rise[RCG_EV_POR] | rise[RCG_EV_DBG];

    assign acc.valid = req_valid;
    assign acc.write = req_write;
    assign acc.control_register_move = req_control_register_move;
    assign acc.addr  = req_addr;
    assign acc.ctx   = req_ctx;
    assign acc.lock  = q.lock;

    rcg_acc_chk u_chk (
        .acc (acc.chk)
    );

    // Read data; any context, lock or not, reserved bits zero
    always_comb begin
        if (acc.tgt == RCG_T_STAT) begin
            rd_mux = {30'h0, q.stat};
        end else if (acc.tgt == RCG_T_GATE) begin
            rd_mux = {18'h0, q.gate};
        end else if (acc.tgt == RCG_T_LOCK) begin
            rd_mux = {31'h0, q.lock};
        end else begin
            rd_mux = 32'h0;
        end
    end

    // Next state
    always_comb begin
        d      = q;
        d.s1   = pins;
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.full = 1'b0;
        d.part = 1'b0;
        d.rvld = req_valid && !req_write;
        d.rdata = (req_valid && !req_write) ? rd_mux : 32'h0;

        // Software writes; reserved bits never stored
        if (acc.wr_ok) begin
            case (acc.tgt)
                RCG_T_STAT: begin
                    // Only selects the next reset's kind
                    d.stat[RCG_POR_BIT] = req_wdata[RCG_POR_BIT];
                end
                RCG_T_GATE: begin
                    d.gate = req_wdata[RCG_GATE_W-1:0] & RCG_GATE_MASK[RCG_GATE_W-1:0];
                end
                RCG_T_LOCK: begin
                    d.lock = req_wdata[RCG_LOCK_BIT];
                end
                default: begin
                    d.lock = q.lock;
                end
            endcase
        end

        // Reset events win over a software write in the same cycle
        if (hard) begin
            d.stat = RCG_STAT_RST[RCG_STAT_W-1:0];
            d.gate = RCG_GATE_RST[RCG_GATE_W-1:0];
            d.lock = RCG_LOCK_RST;
            d.full = 1'b1;
        end else if (rise[RCG_EV_WDT] || rise[RCG_EV_PIN]) begin
            // Watchdog sets its flag, pin clears it
            d.stat[RCG_WDT_BIT] = rise[RCG_EV_WDT];
            d.stat[RCG_POR_BIT] = q.stat[RCG_POR_BIT];
            d.lock = RCG_LOCK_RST;
            if (q.stat[RCG_POR_BIT]) begin
                d.gate = RCG_GATE_RST[RCG_GATE_W-1:0];
                d.full = 1'b1;
            end else begin
                d.gate = q.gate;
                d.part = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q      <= '0;
            q.stat <= RCG_STAT_RST[RCG_STAT_W-1:0];
            q.gate <= RCG_GATE_RST[RCG_GATE_W-1:0];
            q.lock <= RCG_LOCK_RST;
        end else begin
            q <= d;
        end
    end

    // Enables are a register stage behind the mask
    rcg_clk_en #(
        .W (RCG_GATE_W)
    ) u_ce (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .gate     (q.gate),
        .clk_en   (periph_clk_en),
        .wdt_en   (wdt_clk_en)
    );

    assign rsp_valid = q.rvld;
    assign rsp_rdata = q.rdata;
    assign full_init = q.full;
    assign part_init = q.part;

    // Writes from other contexts leave every register alone
    property p_nonmaster_stat;
        @(posedge core_clk) disable iff (!rst_n)
        req_valid && req_write && req_ctx != RCG_MASTER_CTX && rise == '0
        |=> $stable(q.stat) && $stable(q.gate) && $stable(q.lock);
    endproperty
    a_nonmaster_stat: assert property (p_nonmaster_stat) else $error("non-master write took effect");

    // Lock set: memory-path writes are dropped even from the master
    property p_lock_blocks;
        @(posedge core_clk) disable iff (!rst_n)
        q.lock && req_valid && req_write && !req_control_register_move && rise == '0
        |=> $stable(q.gate) && $stable(q.stat);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked write took effect");

    // Watchdog event sets its flag, keeps the power-on flag
    property p_wdt_flag;
        @(posedge core_clk) disable iff (!rst_n)
        rise[RCG_EV_WDT] && !hard |=> q.stat[RCG_WDT_BIT] && q.stat[RCG_POR_BIT] == $past(q.stat[RCG_POR_BIT]);
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

    // Power-on or debug event restores every default
    property p_hard_reset;
        @(posedge core_clk) disable iff (!rst_n)
        hard |=> q.stat == RCG_STAT_RST[RCG_STAT_W-1:0] && q.gate == RCG_GATE_RST[RCG_GATE_W-1:0]
            && !q.lock && full_init;
    endproperty
    a_hard_reset: assert property (p_hard_reset) else $error("power-on event wrong result");

    // Pin event with the flag clear keeps the gate
    property p_pin_keep;
        @(posedge core_clk) disable iff (!rst_n)
        rise == 4'h8 && !q.stat[RCG_POR_BIT] |=> $stable(q.gate) && part_init && !q.stat[RCG_WDT_BIT];
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("pin reset changed gate");

    // Pin event with the flag set masks every peripheral clock
    property p_pin_mask;
        @(posedge core_clk) disable iff (!rst_n)
        rise == 4'h8 && q.stat[RCG_POR_BIT] |=> q.gate == RCG_GATE_RST[RCG_GATE_W-1:0] ##1 periph_clk_en == '0;
    endproperty
    a_pin_mask: assert property (p_pin_mask) else $error("pin reset did not mask clocks");

    // Status reads answer from any context
    property p_read_any;
        @(posedge core_clk) disable iff (!rst_n)
        req_valid && !req_write && !req_control_register_move && req_addr == RCG_STAT_ADDR
        |=> rsp_valid && rsp_rdata == {30'h0, $past(q.stat)};
    endproperty
    a_read_any: assert property (p_read_any) else $error("status read wrong");

    // Master lock write on the control-register move path lands when no reset event comes in the same cycle
    property p_lock_write;
        @(posedge core_clk) disable iff (!rst_n)
        req_valid && req_write && req_control_register_move && req_addr == RCG_LOCK_ADDR
        && req_ctx == RCG_MASTER_CTX && rise == '0
        |=> q.lock == $past(req_wdata[RCG_LOCK_BIT]);
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("master lock write lost");

    // Flag write only picks the next reset's kind
    property p_por_write;
        @(posedge core_clk) disable iff (!rst_n)
        acc.wr_ok && acc.tgt == RCG_T_STAT && rise == '0
        |=> q.stat[RCG_POR_BIT] == $past(req_wdata[0]) && !full_init && !part_init;
    endproperty
    a_por_write: assert property (p_por_write) else $error("flag write misbehaved");

    // Block reset loads the values after reset
    property p_after_reset;
        @(posedge core_clk)
        !rst_n |=> q.stat == RCG_STAT_RST[RCG_STAT_W-1:0] && q.gate == RCG_GATE_RST[RCG_GATE_W-1:0] && !q.lock;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("reset values wrong");

    // No read, no answer; the data lines rest at zero
    property p_rsp_idle;
        @(posedge core_clk) disable iff (!rst_n)
        !(req_valid && !req_write) |=> !rsp_valid && rsp_rdata == 32'h0;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer without a read");

    // Unmapped places still answer, with zero
    property p_unmapped_read;
        @(posedge core_clk) disable iff (!rst_n)
        req_valid && !req_write && acc.tgt == RCG_T_NONE |=> rsp_valid && rsp_rdata == 32'h0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // Lock reads back on the control-register move path
    property p_lock_read;
        @(posedge core_clk) disable iff (!rst_n)
        req_valid && !req_write && req_control_register_move && req_addr == RCG_LOCK_ADDR
        |=> rsp_valid && rsp_rdata == {31'h0, $past(q.lock)};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

    // Memory-path writes never reach the lock
    property p_lock_mem_path;
        @(posedge core_clk) disable iff (!rst_n)
        req_valid && req_write && !req_control_register_move && rise == '0 |=> $stable(q.lock);
    endproperty
    a_lock_mem_path: assert property (p_lock_mem_path) else $error("lock written on memory path");

    // Every reset event reopens the protected registers
    property p_event_unlock;
        @(posedge core_clk) disable iff (!rst_n)
        rise != '0 |=> !q.lock;
    endproperty
    a_event_unlock: assert property (p_event_unlock) else $error("lock kept over reset event");

    // Pin event clears the watchdog flag, keeps the power-on flag
    property p_pin_flag;
        @(posedge core_clk) disable iff (!rst_n)
        rise == 4'h8 |=> !q.stat[RCG_WDT_BIT] && q.stat[RCG_POR_BIT] == $past(q.stat[RCG_POR_BIT]);
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin event flags wrong");

    // Software can never move the watchdog flag
    property p_wdt_ro;
        @(posedge core_clk) disable iff (!rst_n)
        rise == '0 |=> $stable(q.stat[RCG_WDT_BIT]);
    endproperty
    a_wdt_ro: assert property (p_wdt_ro) else $error("watchdog flag moved");

    // Without an event there is no init pulse
    property p_no_self_reset;
        @(posedge core_clk) disable iff (!rst_n)
        rise == '0 |=> !full_init && !part_init;
    endproperty
    a_no_self_reset: assert property (p_no_self_reset) else $error("init pulse without event");

    // One kind of init at a time
    property p_init_excl;
        @(posedge core_clk) disable iff (!rst_n)
        !(full_init && part_init);
    endproperty
    a_init_excl: assert property (p_init_excl) else $error("both init pulses");

    // Reserved gate positions never hold a one
    property p_gate_resv;
        @(posedge core_clk) disable iff (!rst_n)
        (q.gate & ~RCG_GATE_MASK[RCG_GATE_W-1:0]) == '0;
    endproperty
    a_gate_resv: assert property (p_gate_resv) else $error("reserved gate bit set");

    // Accepted gate write stores its implemented bits
    property p_gate_write;
        @(posedge core_clk) disable iff (!rst_n)
        acc.wr_ok && acc.tgt == RCG_T_GATE && rise == '0
        |=> q.gate == ($past(req_wdata[RCG_GATE_W-1:0]) & RCG_GATE_MASK[RCG_GATE_W-1:0]);
    endproperty
    a_gate_write: assert property (p_gate_write) else $error("gate write lost");

endmodule

// ===== rcg_pkg.sv
// Constants and types shared by the reset-cause, clock-gate and write-lock block
// What this block does
// - Reset-status writes from master context only
// - Watchdog flag set by watchdog, read-only
// - Power-on flag set by hardware, software writable
// - Power-on flag chooses full or kept registers
// - Writing power-on flag never causes reset
// - Reset-status resets to 0x00000001
// - Clock-gate writes from master context only
// - Gate bit one stops peripheral clock
// - Power-on reset sets clock gate 0x3F0F
// - Pin reset without power-on keeps gate
// - Watchdog clock never gated
// - Non-master protected writes dropped silently
// - Lock set drops master protected writes
// - Protected registers readable always by anyone
// - Lock bit zero after reset, one blocks
// - Lock reachable only by control move 0xFFE
// - Master may set or clear lock anytime
// - Flags per reset kind set or cleared
// - Pin reset with flag set masks clocks
package rcg_pkg;

    // Register addresses: lock on the control-move path, others on memory path
    localparam logic [11:0] RCG_LOCK_ADDR = 12'hFFE;
    localparam logic [11:0] RCG_STAT_ADDR = 12'h000;
    localparam logic [11:0] RCG_GATE_ADDR = 12'h004;

    // Context allowed to write protected registers
    localparam logic [2:0]  RCG_MASTER_CTX = 3'h0;

    // Field positions
    localparam int          RCG_POR_BIT  = 0;
    localparam int          RCG_WDT_BIT  = 1;
    localparam int          RCG_LOCK_BIT = 0;

    // Widths of the stored fields
    localparam int          RCG_STAT_W = 2;
    localparam int          RCG_GATE_W = 14;

    // Values after reset and masks of implemented bits
    localparam logic [31:0] RCG_STAT_RST  = 32'h00000001;
    localparam logic [31:0] RCG_GATE_RST  = 32'h00003F0F;
    localparam logic        RCG_LOCK_RST  = 1'h0;
    localparam logic [31:0] RCG_GATE_MASK = 32'h00003F0F;

    // Reset event inputs, index into the synchroniser vector
    localparam int          RCG_EV_POR = 0;
    localparam int          RCG_EV_DBG = 1;
    localparam int          RCG_EV_WDT = 2;
    localparam int          RCG_EV_PIN = 3;
    localparam int          RCG_EV_N   = 4;

    // Decoded target of a request
    typedef enum logic [1:0] {
        RCG_T_NONE,
        RCG_T_STAT,
        RCG_T_GATE,
        RCG_T_LOCK
    } rcg_tgt_t;

endpackage

// ===== rcg_acc_if.sv
// Interface between the top and its access checker
`timescale 1ns/1ps
interface rcg_acc_if;
    import rcg_pkg::*;
    logic        valid;  // Request present
    logic        write;  // Request is a write
    logic        control_register_move;  // Control-register move path
    logic [11:0] addr;   // Register address
    logic [2:0]  ctx;    // Issuing context
    logic        lock;   // Current lock bit
    rcg_tgt_t    tgt;    // Decoded register
    logic        wr_ok;  // Write may take effect

    modport top (output valid, write, control_register_move, addr, ctx, lock, input tgt, wr_ok);
    modport chk (input valid, write, control_register_move, addr, ctx, lock, output tgt, wr_ok);
endinterface

// ===== rcg_acc_chk.sv
// Address decode and write permission for the protected registers
`timescale 1ns/1ps
module rcg_acc_chk
    import rcg_pkg::*;
(
    rcg_acc_if.chk acc  // Request in, decision out
);

    logic master;  // Request comes from the master context

    // Decode; the lock only answers on the control-move path
    always_comb begin
        if (acc.control_register_move && acc.addr == RCG_LOCK_ADDR) begin
            acc.tgt = RCG_T_LOCK;
        end else if (!acc.control_register_move && acc.addr == RCG_STAT_ADDR) begin
            acc.tgt = RCG_T_STAT;
        end else if (!acc.control_register_move && acc.addr == RCG_GATE_ADDR) begin
            acc.tgt = RCG_T_GATE;
        end else begin
            acc.tgt = RCG_T_NONE;
        end
    end

    assign master = (acc.ctx == RCG_MASTER_CTX);

    // Dropped writes raise nothing: there is simply no strobe
    always_comb begin
        acc.wr_ok = 1'b0;
        if (acc.valid && acc.write && master) begin
            if (acc.tgt == RCG_T_LOCK) begin
                acc.wr_ok = 1'b1;
            end else if (acc.tgt != RCG_T_NONE) begin
                acc.wr_ok = !acc.lock;
            end
        end
    end

endmodule

// ===== rcg_clk_en.sv
// Per-peripheral clock enables derived from the gate mask
`timescale 1ns/1ps
module rcg_clk_en
    import rcg_pkg::*;
#(
    parameter int W = RCG_GATE_W  // Number of gate bits
)(
    input  wire logic         core_clk,  // System clock
    input  wire logic         rst_n,     // Synchronous reset, active low
    input  wire logic [W-1:0] gate,      // Stop mask, one stops a clock
    output logic [W-1:0]      clk_en,    // Enable per peripheral
    output logic              wdt_en     // Watchdog clock enable
);

    typedef struct packed {
        logic [W-1:0] en;   // Registered enables
        logic         wdt;  // Watchdog enable
    } rcg_ce_st_t;

    rcg_ce_st_t   q;     // Current state
    rcg_ce_st_t   d;     // Next state
    logic [W-1:0] en_d;  // Enable per bit

    // Reserved positions never enable anything
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign en_d[i] = ~gate[i] & RCG_GATE_MASK[i];
    end

    // Next state
    always_comb begin
        d     = q;
        d.en  = en_d;
        d.wdt = 1'b1;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q     <= '0;
            q.wdt <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign clk_en = q.en;
    assign wdt_en = q.wdt;

    property p_en_follows;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> clk_en == (~$past(gate) & RCG_GATE_MASK[W-1:0]);
    endproperty
    a_en_follows: assert property (p_en_follows) else $error("enable not inverse of gate");

    property p_wdt_on;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> wdt_en ##1 wdt_en;
    endproperty
    a_wdt_on: assert property (p_wdt_on) else $error("watchdog clock gated");

endmodule

// ===== tb.sv
// Self-checking testbench for the reset-cause, clock-gate and write-lock block
`timescale 1ns/1ps
module tb;
    import rcg_pkg::*;

    logic        core_clk;       // System clock, 25 ns period
    logic        rst_n;          // Synchronous reset, active low
    logic [3:0]  evt;            // Reset event pins, indexed by RCG_EV_*
    logic        req_valid;      // Register request
    logic        req_write;      // Request is a write
    logic        req_control_register_move; // Control-register move path
    logic [11:0] req_addr;       // Register address
    logic [2:0]  req_ctx;        // Issuing context
    logic [31:0] req_wdata;      // Write data
    logic        rsp_valid;      // Read answer valid
    logic [31:0] rsp_rdata;      // Read answer data
    logic        full_init;      // Reset with defaults
    logic        part_init;      // Reset with registers kept
    logic [13:0] periph_clk_en;  // Peripheral clock enables
    logic        wdt_clk_en;     // Watchdog clock enable
    logic [31:0] e_stat;         // Expected status register
    logic [31:0] e_gate;         // Expected clock-gate register
    logic        e_lock;         // Expected lock bit
    logic [31:0] d;              // Random write data
    logic [2:0]  c;              // Random context
    logic [1:0]  k;              // Random target choice
    integer      seed = 36;      // Fixed seed keeps runs repeatable
    int          bad_count;      // Mismatches seen
    int          n_compared;     // Comparisons made
    int          cycles;         // Clock cycles since start

    rcg_top i_rcg_top (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .por_evt       (evt[RCG_EV_POR]),
        .dbg_evt       (evt[RCG_EV_DBG]),
        .wdt_evt       (evt[RCG_EV_WDT]),
        .pin_evt       (evt[RCG_EV_PIN]),
        .req_valid     (req_valid),
        .req_write     (req_write),
        .req_control_register_move (req_control_register_move),
        .req_addr      (req_addr),
        .req_ctx       (req_ctx),
        .req_wdata     (req_wdata),
        .rsp_valid     (rsp_valid),
        .rsp_rdata     (rsp_rdata),
        .full_init     (full_init),
        .part_init     (part_init),
        .periph_clk_en (periph_clk_en),
        .wdt_clk_en    (wdt_clk_en)
    );

    // Free-running system clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    // Verdict and end of run
    task automatic finish_test;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compare with four-state equality so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Expected register after a write: only master, only unlocked, only writable bits
    function automatic logic [31:0] after_wr(logic [31:0] old, logic [31:0] wd, logic [31:0] msk,
                                             logic [2:0] cx, logic lk);
        after_wr = (cx == RCG_MASTER_CTX && !lk) ? ((wd & msk) | (old & ~msk)) : old;
    endfunction

    // Put one request on the port
    task automatic drive(input logic v, w, m, input logic [11:0] a, input logic [2:0] cx,
                         input logic [31:0] wd);
        req_valid = v;
        req_write = w;
        req_control_register_move = m;
        req_addr  = a;
        req_ctx   = cx;
        req_wdata = wd;
    endtask

    // Write; a write never brings an init pulse of its own
    task automatic wr(input logic m, input logic [11:0] a, input logic [2:0] cx, input logic [31:0] wd);
        @(negedge core_clk);
        drive(1'b1, 1'b1, m, a, cx, wd);
        @(negedge core_clk);
        req_valid = 1'b0;
        check({30'h0, full_init, part_init}, 32'h0);
    endtask

    // Read; the answer stands in the cycle after the taking edge
    task automatic rd(input logic m, input logic [11:0] a, input logic [2:0] cx, input logic [31:0] e);
        @(negedge core_clk);
        drive(1'b1, 1'b0, m, a, cx, $random(seed));
        @(negedge core_clk);
        req_valid = 1'b0;
        check({31'h0, rsp_valid}, 32'h1);
        check(rsp_rdata, e);
    endtask

    // Read back all three registers from a given context and check the enables
    task automatic rd_all(input logic [2:0] cx);
        rd(1'b0, RCG_STAT_ADDR, cx, e_stat);
        rd(1'b0, RCG_GATE_ADDR, cx, e_gate);
        rd(1'b1, RCG_LOCK_ADDR, cx, {31'h0, e_lock});
        check({18'h0, periph_clk_en}, {18'h0, ~e_gate[13:0] & RCG_GATE_MASK[13:0]});
        check({31'h0, wdt_clk_en}, 32'h1);
    endtask

    // Raise one reset event pin and check the pulse three edges later
    task automatic ev(input int idx);
        logic fl;
        logic full;
        fl   = e_stat[RCG_POR_BIT];
        full = (idx == RCG_EV_POR) || (idx == RCG_EV_DBG) || fl;
        @(negedge core_clk);
        evt[idx] = 1'b1;
        repeat (3) @(negedge core_clk);
        check({30'h0, full_init, part_init}, {30'h0, full, !full});
        evt[idx] = 1'b0;
        if (idx == RCG_EV_POR || idx == RCG_EV_DBG) begin
            e_stat = RCG_STAT_RST;
        end else begin
            e_stat = {30'h0, idx == RCG_EV_WDT, fl};
        end
        if (full) begin
            e_gate = RCG_GATE_RST;
        end
        e_lock = 1'b0;
        @(negedge core_clk);
        check({30'h0, full_init, part_init}, 32'h0);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        evt   = 4'h0;
        drive(1'b0, 1'b0, 1'b0, 12'h000, 3'h0, 32'h0);
        e_stat = RCG_STAT_RST;
        e_gate = RCG_GATE_RST;
        e_lock = RCG_LOCK_RST;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        // Values straight after reset
        rd(1'b0, RCG_STAT_ADDR, 3'h3, 32'h00000001);
        rd(1'b0, RCG_GATE_ADDR, 3'h1, 32'h00003F0F);
        rd(1'b1, RCG_LOCK_ADDR, 3'h0, 32'h0);
        rd_all(3'h4);
        // Unmapped places, including the lock address on the memory path
        rd(1'b0, 12'h008, 3'h2, 32'h0);
        rd(1'b0, RCG_LOCK_ADDR, 3'h0, 32'h0);
        // Random writes from random contexts with the lock toggling
        for (int i = 0; i < 40; i++) begin
            c = ($random(seed) & 1) ? RCG_MASTER_CTX : 3'($random(seed));
            d = $random(seed);
            k = 2'($random(seed));
            case (k)
                2'h0: begin
                    wr(1'b0, RCG_STAT_ADDR, c, d);
                    e_stat = after_wr(e_stat, d, 32'h1, c, e_lock);
                end
                2'h1: begin
                    wr(1'b0, RCG_GATE_ADDR, c, d);
                    e_gate = after_wr(e_gate, d, RCG_GATE_MASK, c, e_lock);
                end
                2'h2: begin
                    wr(1'b1, RCG_LOCK_ADDR, c, d);
                    e_lock = (c == RCG_MASTER_CTX) ? d[RCG_LOCK_BIT] : e_lock;
                end
                default: begin
                    wr(1'b0, RCG_LOCK_ADDR, c, d);
                end
            endcase
            rd_all(3'($random(seed)));
        end
        // Mid-run block reset brings every register back to its value after reset
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        e_stat = RCG_STAT_RST;
        e_gate = RCG_GATE_RST;
        e_lock = RCG_LOCK_RST;
        rd_all(3'h2);
        // Every reset kind, with the power-on flag clear and set, lock set beforehand
        for (int f = 0; f < 2; f++) begin
            for (int idx = 0; idx < RCG_EV_N; idx++) begin
                wr(1'b1, RCG_LOCK_ADDR, RCG_MASTER_CTX, 32'h0);
                e_lock = 1'b0;
                d = $random(seed);
                wr(1'b0, RCG_GATE_ADDR, RCG_MASTER_CTX, d);
                e_gate = d & RCG_GATE_MASK;
                wr(1'b0, RCG_STAT_ADDR, RCG_MASTER_CTX, 32'(f));
                e_stat = after_wr(e_stat, 32'(f), 32'h1, RCG_MASTER_CTX, 1'b0);
                wr(1'b1, RCG_LOCK_ADDR, RCG_MASTER_CTX, 32'h1);
                e_lock = 1'b1;
                ev(idx);
                rd_all(RCG_MASTER_CTX);
            end
        end
        finish_test();
    end
endmodule
